// file: fifo_port_pkg.sv
// Constants shared by the byte FIFO parallel port and its channel engine.
// Assumes one 50 MHz clock.
package fifo_port_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_NS     = 20;   // System clock period
    localparam int PORT_CLK_DIV   = 2;    // System cycles per port clock period
    localparam int FLAG_GAP_NS    = 49;   // Least flag inactive time after a strobe
    // Rounded up to whole cycles
    localparam int FLAG_GAP_CYC   = (FLAG_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int GAP_W          = 4;    // Width of the flag gap counter

    // ------------------------------------------------------------------
    // Reset values of pin outputs
    // ------------------------------------------------------------------
    localparam logic FLAG_RESET   = 1'b1; // Flags inactive (high) after reset
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Port operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_ASYNC = 2'b01,
        MODE_SYNC  = 2'b10
    } port_mode_t;

endpackage : fifo_port_pkg

// file: async_fifo_channel.sv
// Asynchronous strobe FIFO engine for one channel.
// Assumes strobes synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none

module async_fifo_channel
    import fifo_port_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              enable,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [DATA_W-1:0] bus_in,
    output logic      [DATA_W-1:0] bus_out,
    output logic                   bus_oe,
    output logic                   rx_data_avail_n,
    output logic                   tx_space_avail_n,
    input  wire logic              rx_in_valid,
    input  wire logic [DATA_W-1:0] rx_in_data,
    output logic                   rx_in_ready,
    output logic                   tx_out_valid,
    output logic      [DATA_W-1:0] tx_out_data,
    input  wire logic              tx_out_ready
);

    // ------------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------------
    logic             rd_n_q, wr_n_q;
    logic             rd_fall, rd_rise, wr_fall, wr_rise;
    logic             rx_full_q, tx_full_q;
    logic [GAP_W-1:0] rx_gap_q, tx_gap_q;
    logic             rx_load, tx_take;

    // Previous strobe levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            rd_n_q <= rd_n;
            wr_n_q <= wr_n;
        end
    end

    assign rd_fall = enable && rd_n_q && !rd_n;
    assign rd_rise = !rd_n_q && rd_n;
    assign wr_fall = enable && wr_n_q && !wr_n;
    assign wr_rise = !wr_n_q && wr_n;

    // ------------------------------------------------------------------
    // Read side: one holding byte that is the bus data
    // ------------------------------------------------------------------
    // Reload only when idle, so bus data stays put
    assign rx_load     = !rx_full_q && rd_n && (rx_gap_q == '0) && enable;
    assign rx_in_ready = rx_load;

    // Byte leaves on the falling read edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_q <= 1'b0;
            bus_out   <= DATA_RESET;
        end else if (rd_fall && !rx_data_avail_n) begin
            rx_full_q <= 1'b0;
        end else if (rx_load && rx_in_valid) begin
            rx_full_q <= 1'b1;
            bus_out   <= rx_in_data;
        end
    end

    // Gap after each read strobe cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_gap_q <= '0;
        end else if (rd_rise) begin
            rx_gap_q <= GAP_W'(FLAG_GAP_CYC);
        end else if (rx_gap_q != '0) begin
            rx_gap_q <= rx_gap_q - 1'b1;
        end
    end

    // Data flag, high through strobe and gap
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_avail_n <= FLAG_RESET;
        end else begin
            rx_data_avail_n <= !(enable && rx_full_q && rd_n && !rd_fall
                                 && (rx_gap_q == '0));
        end
    end

    assign bus_oe = enable && !rd_n;

    // ------------------------------------------------------------------
    // Write side: byte captured on the falling write edge
    // ------------------------------------------------------------------
    assign tx_take = wr_fall && !tx_space_avail_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_full_q   <= 1'b0;
            tx_out_data <= DATA_RESET;
        end else if (tx_take) begin
            tx_full_q   <= 1'b1;
            tx_out_data <= bus_in;
        end else if (tx_out_ready) begin
            tx_full_q   <= 1'b0;
        end
    end

    assign tx_out_valid = tx_full_q;

    // Gap after each write strobe cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_gap_q <= '0;
        end else if (wr_rise) begin
            tx_gap_q <= GAP_W'(FLAG_GAP_CYC);
        end else if (tx_gap_q != '0) begin
            tx_gap_q <= tx_gap_q - 1'b1;
        end
    end

    // Space flag, inactive while strobe low, buffer full or gap running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_space_avail_n <= FLAG_RESET;
        end else begin
            tx_space_avail_n <= !(enable && !tx_full_q && !tx_take && wr_n
                                  && (tx_gap_q == '0));
        end
    end

endmodule : async_fifo_channel

`default_nettype wire

// file: byte_fifo_parallel_port.sv
// Byte-wide parallel FIFO port: two async strobe channels, sync mode on the first.
// Assumes synchronous pins and valid/ready USB-side streams.
`timescale 1ns/1ns
`default_nettype none

module byte_fifo_parallel_port
    import fifo_port_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              async_sel_a,
    input  wire logic              async_sel_b,
    input  wire logic              sync_req,
    output logic      [1:0]        port_mode,
    output logic                   port_clock_out,
    input  wire logic              oe_n,
    input  wire logic              rd_a_n,
    input  wire logic              wr_a_n,
    input  wire logic [DATA_W-1:0] bus_a_in,
    output logic      [DATA_W-1:0] bus_a_out,
    output logic                   bus_a_oe,
    output logic                   rx_data_avail_a_n,
    output logic                   tx_space_avail_a_n,
    input  wire logic              rd_b_n,
    input  wire logic              wr_b_n,
    input  wire logic [DATA_W-1:0] bus_b_in,
    output logic      [DATA_W-1:0] bus_b_out,
    output logic                   bus_b_oe,
    output logic                   rx_data_avail_b_n,
    output logic                   tx_space_avail_b_n,
    input  wire logic              rx_a_valid,
    input  wire logic [DATA_W-1:0] rx_a_data,
    output logic                   rx_a_ready,
    output logic                   tx_a_valid,
    output logic      [DATA_W-1:0] tx_a_data,
    input  wire logic              tx_a_ready,
    input  wire logic              rx_b_valid,
    input  wire logic [DATA_W-1:0] rx_b_data,
    output logic                   rx_b_ready,
    output logic                   tx_b_valid,
    output logic      [DATA_W-1:0] tx_b_data,
    input  wire logic              tx_b_ready
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (DATA_W != 8) begin : g_bad_width
            $error("DATA_W must be 8");
        end
        if (PORT_CLK_DIV != 2) begin : g_bad_div
            $error("PORT_CLK_DIV must be 2");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------------
    port_mode_t mode_q, mode_d;
    logic       sync_on;

    // Sync only reachable from async with both channels selected
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_OFF: begin
                if (async_sel_a && async_sel_b) begin
                    mode_d = MODE_ASYNC;
                end
            end
            MODE_ASYNC: begin
                if (!(async_sel_a && async_sel_b)) begin
                    mode_d = MODE_OFF;
                end else if (sync_req) begin
                    mode_d = MODE_SYNC;
                end
            end
            MODE_SYNC: begin
                if (!(async_sel_a && async_sel_b)) begin
                    mode_d = MODE_OFF;
                end else if (!sync_req) begin
                    mode_d = MODE_ASYNC;
                end
            end
            default: begin
                mode_d = MODE_OFF;
            end
        endcase
    end

    // Mode register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign port_mode = mode_q;
    assign sync_on   = (mode_q == MODE_SYNC);

    // ------------------------------------------------------------------
    // Port clock divider and rising edge enable
    // ------------------------------------------------------------------
    logic clk_rise;

    // Toggles each cycle in sync mode, held low otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_clock_out <= 1'b0;
        end else if (sync_on) begin
            port_clock_out <= !port_clock_out;
        end else begin
            port_clock_out <= 1'b0;
        end
    end

    // The cycle whose end raises the port clock
    assign clk_rise = sync_on && !port_clock_out;

    // ------------------------------------------------------------------
    // Synchronous read path
    // ------------------------------------------------------------------
    logic              srx_full_q;
    logic [DATA_W-1:0] srx_data_q;
    logic              srx_flag_n_q;
    logic              srx_take;
    logic              srx_load;

    // Read take: rise edge, flag, enable, read low
    assign srx_take = clk_rise && !srx_flag_n_q && !oe_n && !rd_a_n;
    assign srx_load = sync_on && (!srx_full_q || srx_take);

    // Holding byte; refilled on the same edge it is taken
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srx_full_q <= 1'b0;
            srx_data_q <= DATA_RESET;
        end else if (srx_load && rx_a_valid) begin
            srx_full_q <= 1'b1;
            srx_data_q <= rx_a_data;
        end else if (srx_take || !sync_on) begin
            srx_full_q <= 1'b0;
        end
    end

    // Data flag updated only at port clock rising edges in sync mode, forced high otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srx_flag_n_q <= FLAG_RESET;
        end else if (!sync_on) begin
            srx_flag_n_q <= FLAG_RESET;
        end else if (clk_rise) begin
            // Low while a byte is held, high once the last is taken
            srx_flag_n_q <= !((srx_full_q && !srx_take) ||
                              (srx_load && rx_a_valid));
        end
    end

    // ------------------------------------------------------------------
    // Synchronous write path
    // ------------------------------------------------------------------
    logic              stx_full_q;
    logic [DATA_W-1:0] stx_data_q;
    logic              stx_flag_n_q;
    logic              stx_take;
    logic              stx_drain;

    // Write refused while the bus is turned toward a read
    assign stx_take  = clk_rise && !stx_flag_n_q && !wr_a_n && oe_n;
    assign stx_drain = stx_full_q && tx_a_ready;

    // Holding byte for the transmit stream
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stx_full_q <= 1'b0;
            stx_data_q <= DATA_RESET;
        end else if (stx_take) begin
            stx_full_q <= 1'b1;
            stx_data_q <= bus_a_in;
        end else if (stx_drain) begin
            stx_full_q <= 1'b0;
        end
    end

    // Space flag low while the stream keeps up
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stx_flag_n_q <= FLAG_RESET;
        end else if (!sync_on) begin
            stx_flag_n_q <= FLAG_RESET;
        end else if (clk_rise) begin
            stx_flag_n_q <= (stx_full_q || stx_take) && !tx_a_ready;
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous channel engines
    // ------------------------------------------------------------------
    logic              arx_a_ready, atx_a_valid;
    logic [DATA_W-1:0] atx_a_data, abus_a_out;
    logic              abus_a_oe, arxf_a_n, atxe_a_n;
    logic              async_a_en, async_b_en;

    // A leaves async during sync; B stays
    assign async_a_en = (mode_q == MODE_ASYNC);
    assign async_b_en = (mode_q != MODE_OFF);

    // First channel engine
    async_fifo_channel #(
        .DATA_W (DATA_W)
    ) u_async_a (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .enable           (async_a_en),
        .rd_n             (rd_a_n),
        .wr_n             (wr_a_n),
        .bus_in           (bus_a_in),
        .bus_out          (abus_a_out),
        .bus_oe           (abus_a_oe),
        .rx_data_avail_n  (arxf_a_n),
        .tx_space_avail_n (atxe_a_n),
        .rx_in_valid      (rx_a_valid),
        .rx_in_data       (rx_a_data),
        .rx_in_ready      (arx_a_ready),
        .tx_out_valid     (atx_a_valid),
        .tx_out_data      (atx_a_data),
        .tx_out_ready     (tx_a_ready)
    );

    // Second channel engine, async only
    async_fifo_channel #(
        .DATA_W (DATA_W)
    ) u_async_b (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .enable           (async_b_en),
        .rd_n             (rd_b_n),
        .wr_n             (wr_b_n),
        .bus_in           (bus_b_in),
        .bus_out          (bus_b_out),
        .bus_oe           (bus_b_oe),
        .rx_data_avail_n  (rx_data_avail_b_n),
        .tx_space_avail_n (tx_space_avail_b_n),
        .rx_in_valid      (rx_b_valid),
        .rx_in_data       (rx_b_data),
        .rx_in_ready      (rx_b_ready),
        .tx_out_valid     (tx_b_valid),
        .tx_out_data      (tx_b_data),
        .tx_out_ready     (tx_b_ready)
    );

    // ------------------------------------------------------------------
    // First channel pin and stream selection
    // ------------------------------------------------------------------
    // Sync drives the bus only while output enable is low
    assign bus_a_oe  = sync_on ? !oe_n : abus_a_oe;
    assign bus_a_out = sync_on ? srx_data_q : abus_a_out;

    assign rx_data_avail_a_n  = sync_on ? srx_flag_n_q : arxf_a_n;
    assign tx_space_avail_a_n = sync_on ? stx_flag_n_q : atxe_a_n;

    // Stream handshakes follow the active engine
    assign rx_a_ready = sync_on ? srx_load : arx_a_ready;
    assign tx_a_valid = sync_on ? stx_full_q : atx_a_valid;
    assign tx_a_data  = sync_on ? stx_data_q : atx_a_data;

endmodule : byte_fifo_parallel_port

`default_nettype wire

// file: fifo_port_properties.sv
// Checker for the byte FIFO port pins.
// Assumes one 50 MHz clock and an active-low async reset.
`timescale 1ns/1ns
`default_nettype none
module fifo_port_properties (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       async_sel_a,
    input wire logic       async_sel_b,
    input wire logic       sync_req,
    input wire logic [1:0] port_mode,
    input wire logic       port_clock_out,
    input wire logic       oe_n,
    input wire logic       rd_a_n,
    input wire logic       rd_b_n,
    input wire logic       wr_b_n,
    input wire logic       bus_a_oe,
    input wire logic       bus_b_oe,
    input wire logic       rx_data_avail_a_n,
    input wire logic       tx_space_avail_a_n,
    input wire logic       rx_data_avail_b_n,
    input wire logic       tx_space_avail_b_n
);
    // ------
    // Properties
    // ------
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_clk_idle;
        port_mode != 2'b10 && $past(port_mode) != 2'b10 |-> !port_clock_out;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("port clock moves");
    property p_clk_run;
        port_mode == 2'b10 && $past(port_mode) == 2'b10 |->
            port_clock_out != $past(port_clock_out);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("port clock stuck");
    property p_sync_entry;
        $rose(port_mode[1]) |-> $past(port_mode) == 2'b01
            && $past(sync_req && async_sel_a && async_sel_b);
    endproperty
    a_sync_entry: assert property (p_sync_entry) else $error("bad sync entry");
    property p_sync_oe;
        port_mode == 2'b10 |-> bus_a_oe == !oe_n;
    endproperty
    a_sync_oe: assert property (p_sync_oe) else $error("sync bus enable wrong");
    property p_async_oe;
        port_mode == 2'b01 |-> bus_b_oe == !rd_b_n;
    endproperty
    a_async_oe: assert property (p_async_oe) else $error("async bus enable wrong");
    property p_rd_take;
        port_mode == 2'b01 && $fell(rd_b_n) && !rx_data_avail_b_n |=> rx_data_avail_b_n;
    endproperty
    a_rd_take: assert property (p_rd_take) else $error("read fall not taken");
    property p_rd_gap;
        port_mode == 2'b01 && $rose(rd_b_n) |-> rx_data_avail_b_n [*3];
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("data flag gap short");
    property p_wr_gap;
        port_mode == 2'b01 && $rose(wr_b_n) |-> tx_space_avail_b_n [*3];
    endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("space flag gap short");
    property p_sync_flags;
        port_mode == 2'b10 && $past(port_mode, 2) == 2'b10 && !$rose(port_clock_out)
            |-> $stable(rx_data_avail_a_n) && $stable(tx_space_avail_a_n);
    endproperty
    a_sync_flags: assert property (p_sync_flags) else $error("flag off clock edge");

    // Main scenarios
    c_async_read: cover property ($fell(rd_b_n) && !rx_data_avail_b_n);
    c_sync_entry: cover property ($rose(port_mode[1]));
    c_sync_read: cover property (port_mode == 2'b10 && !oe_n && !rd_a_n && !rx_data_avail_a_n);
endmodule : fifo_port_properties

bind byte_fifo_parallel_port fifo_port_properties u_props (.*);
`default_nettype wire

// file: far_end_model.sv
// Far-end logic model that strobes one channel of the FIFO port.
// Assumes flags and read data are registered on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module far_end_model (
    input  wire logic       sys_clk,
    input  wire logic       port_clock_out,
    input  wire logic       rx_flag_n,
    input  wire logic       tx_flag_n,
    input  wire logic [7:0] bus_out,
    output var  logic       rd_n,
    output var  logic       wr_n,
    output var  logic       oe_n,
    output var  logic [7:0] bus_in
);
    logic [7:0] got[$];
    logic [7:0] wq[$];
    logic       timed_out = 1'b0;

    // ------
    // Transfers
    // ------
    // Strobes idle at time zero
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        oe_n = 1'b1;
        bus_in = 8'h00;
    end

    // Bounded wait for a flag to go active
    task automatic wait_low(input logic tx);
        for (int n = 0; n < 300 && (tx ? tx_flag_n : rx_flag_n) !== 1'b0; n++)
            @(posedge sys_clk);
        if ((tx ? tx_flag_n : rx_flag_n) !== 1'b0)
            timed_out = 1'b1;
    endtask : wait_low

    // Strobe only with the flag active, held 40 ns
    task automatic async_read(output logic [7:0] b);
        wait_low(1'b0);
        @(posedge sys_clk);
        rd_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        b = bus_out;
        rd_n <= 1'b1;
    endtask : async_read

    task automatic async_write(input logic [7:0] b);
        wait_low(1'b1);
        @(posedge sys_clk);
        bus_in <= b;
        @(posedge sys_clk);
        wr_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        wr_n <= 1'b1;
        @(posedge sys_clk);
        bus_in <= ~b; // Stale byte gone
    endtask : async_write

    // Enable first, then hold read low for a burst
    task automatic sync_read(input int cnt);
        got.delete();
        wait_low(1'b0);
        @(posedge sys_clk);
        oe_n <= 1'b0;
        @(posedge sys_clk);
        rd_n <= 1'b0;
        for (int n = 0; n < 300 && got.size() < cnt; n++) begin
            @(posedge sys_clk);
            if (!port_clock_out && !rx_flag_n)
                got.push_back(bus_out);
        end
        rd_n <= 1'b1;
        @(posedge sys_clk);
        oe_n <= 1'b1;
    endtask : sync_read

    // Burst write; a byte counts only with both lows
    task automatic sync_write(input logic oe_lo);
        wait_low(1'b1);
        @(posedge sys_clk);
        oe_n <= ~oe_lo;
        bus_in <= wq[0];
        wr_n <= 1'b0;
        for (int n = 0; n < 300 && wq.size() > 0; n++) begin
            @(posedge sys_clk);
            if (!port_clock_out && !tx_flag_n)
                void'(wq.pop_front());
            if (wq.size() > 0)
                bus_in <= wq[0];
        end
        wr_n <= 1'b1;
        oe_n <= 1'b1;
        bus_in <= ~bus_in;
    endtask : sync_write
endmodule : far_end_model
`default_nettype wire

// file: byte_fifo_parallel_port_tb.sv
// Testbench: both channels async, then channel A in sync mode.
// Assumes package, checker and model compiled first.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo_parallel_port_tb;
    import fifo_port_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       async_sel_a = 1'b0, async_sel_b = 1'b0, sync_req = 1'b0;
    logic [1:0] port_mode;
    logic       port_clock_out, oe_n, rd_a_n, wr_a_n, rd_b_n, wr_b_n;
    logic [7:0] bus_a, bus_b, drv_a, drv_b, bus_a_out, bus_b_out;
    logic       bus_a_oe, bus_b_oe;
    logic       rx_data_avail_a_n, tx_space_avail_a_n, rx_data_avail_b_n, tx_space_avail_b_n;
    logic       rx_a_valid = 1'b0, rx_b_valid = 1'b0, rx_a_ready, rx_b_ready;
    logic [7:0] rx_a_data = 8'h00, rx_b_data = 8'h00, tx_a_data, tx_b_data, b;
    logic       tx_a_valid, tx_b_valid, tx_a_ready = 1'b1, tx_b_ready = 1'b1;
    logic [7:0] qa[$], qb[$], ta[$], tq[$];
    int         mismatches = 0;
    int         checks = 0;

    // ------
    // Harness
    // ------
    always #10 sys_clk = ~sys_clk;
    // Wire level of each shared data bus
    assign bus_a = bus_a_oe ? bus_a_out : drv_a;
    assign bus_b = bus_b_oe ? bus_b_out : drv_b;

    byte_fifo_parallel_port #(.DATA_W(8)) dut (.*, .bus_a_in(bus_a), .bus_b_in(bus_b));
    far_end_model far_a (.sys_clk, .port_clock_out, .rx_flag_n(rx_data_avail_a_n),
        .tx_flag_n(tx_space_avail_a_n), .bus_out(bus_a), .rd_n(rd_a_n), .wr_n(wr_a_n),
        .oe_n, .bus_in(drv_a));
    far_end_model far_b (.sys_clk, .port_clock_out, .rx_flag_n(rx_data_avail_b_n),
        .tx_flag_n(tx_space_avail_b_n), .bus_out(bus_b), .rd_n(rd_b_n), .wr_n(wr_b_n),
        .oe_n(), .bus_in(drv_b));

    // USB-side stream models
    always @(posedge sys_clk) begin
        if (rx_a_valid && rx_a_ready)
            void'(qa.pop_front());
        if (rx_b_valid && rx_b_ready)
            void'(qb.pop_front());
        if (tx_a_valid && tx_a_ready)
            ta.push_back(tx_a_data);
        if (tx_b_valid && tx_b_ready)
            tq.push_back(tx_b_data);
        rx_a_valid <= qa.size() > 0;
        rx_a_data <= qa.size() > 0 ? qa[0] : 8'h00;
        rx_b_valid <= qb.size() > 0;
        rx_b_data <= qb.size() > 0 ? qb[0] : 8'h00;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic wait_tx(input int cnt);
        for (int n = 0; n < 300 && ta.size() + tq.size() < cnt; n++)
            @(posedge sys_clk);
        if (ta.size() + tq.size() < cnt) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_tx

    // ------
    // Scenarios
    // ------
    // Mode stays off until both channels are async
    task automatic t_mode;
        check({6'h0, port_mode}, 8'h00, "mode after reset");
        check({7'h0, rx_data_avail_a_n}, {7'h0, FLAG_RESET}, "flag after reset");
        async_sel_a <= 1'b1;
        sync_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({6'h0, port_mode}, 8'h00, "mode, one select");
        sync_req <= 1'b0;
        async_sel_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({6'h0, port_mode}, {6'h0, MODE_ASYNC}, "mode, both selects");
        check({7'h0, port_clock_out}, 8'h00, "port clock in async");
    endtask : t_mode

    // Async bytes on both channels
    task automatic t_async;
        qb = '{8'h5a, 8'h81};
        qa = '{8'h3c};
        far_b.async_read(b);
        check(b, 8'h5a, "async read b");
        far_b.async_read(b);
        check(b, 8'h81, "async read b again");
        far_a.async_read(b);
        check(b, 8'h3c, "async read a");
        tx_b_ready <= 1'b0;
        far_b.async_write(8'ha5);
        repeat (8) @(posedge sys_clk);
        check({7'h0, tx_space_avail_b_n}, 8'h01, "b space, stream stalled");
        tx_b_ready <= 1'b1;
        far_a.async_write(8'h96);
        wait_tx(2);
        check(tq[0], 8'ha5, "async write b");
        check(ta[0], 8'h96, "async write a");
        ta.delete();
    endtask : t_async

    // Sync read burst; data flag rises after the last byte
    task automatic t_sync_read;
        sync_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({6'h0, port_mode}, {6'h0, MODE_SYNC}, "mode, sync");
        qa = '{8'h01, 8'hfe, 8'h7f};
        far_a.sync_read(3);
        check(far_a.got[0], 8'h01, "sync first byte");
        check(far_a.got[1], 8'hfe, "sync second byte");
        check(far_a.got[2], 8'h7f, "sync last byte");
        repeat (2) @(posedge sys_clk);
        check({7'h0, rx_data_avail_a_n}, 8'h01, "flag after burst");
    endtask : t_sync_read

    // Write burst, then a refused write
    task automatic t_sync_write;
        far_a.wq = '{8'h11, 8'h22, 8'h33};
        far_a.sync_write(1'b0);
        wait_tx(4);
        check(ta[0], 8'h11, "sync write first");
        check(ta[1], 8'h22, "sync write second");
        check(ta[2], 8'h33, "sync write last");
        far_a.wq = '{8'h77};
        far_a.sync_write(1'b1);
        repeat (10) @(posedge sys_clk);
        check(8'(ta.size()), 8'h03, "bytes after refused write");
    endtask : t_sync_write

    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_mode();
        t_async();
        t_sync_read();
        t_sync_write();
        check({7'h0, far_a.timed_out | far_b.timed_out}, 8'h00, "far end waits");
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        complete_run();
    end
endmodule : byte_fifo_parallel_port_tb
`default_nettype wire
